// ==== rtl/fsr_regs.sv ====
`timescale 1ns/1ps

// Summary of operation
// R01: plain mode: status b reads leave bus undriven
// R02: extended bits 0,1 show motor pin states
// R03: extended bit 2 shows write gate level
// R04: extended bits 3,4 toggle on data edges
// R05: extended bit 5 mirrors drive select bit 0
// R06: extended bits 6,7 always read one
// R07: latched bit 2 catches write gate rise
// R08: latched bits 3,4 catch data inactive edges
// R09: latched bits 5,6 show select pins low
// R10: output register writable, hard reset clears
// R11: select field decoded, one drive only
// R12: bit 2 zero holds controller reset
// R13: short soft reset stretched to 100ns
// R14: plain/latched: bit 3 enables dma pins
// R15: extended: dma pins always enabled
// R16: bits 4,5 drive motor outputs
// R17: host writes 1CH or 2DH to activate
// R18: tape register holds assigned drive number
// R19: tape reads float bits 7:2, survive soft reset
// R20: normal decode of selects and motors
// R21: swapped decode exchanges drive 0 and 1
// R22: digital input read clears latched bits
// R23: mode and swap are static inputs
module fsr_regs
#(
   parameter int SOFT_RST_CYC = fsr_pkg::FSR_SOFT_RST_CYC
)
(
   // clock and hardware reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // host i/o port
   input wire logic [9:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic io_wr_in,
   input wire logic [7:0] io_wdata_in,
   output logic [7:0] io_rdata_out,
   output logic [7:0] io_rdata_oe_out,
   // static configuration
   input wire fsr_pkg::fsr_mode_t mode_in,
   input wire logic swap_drives_in,
   // drive activity from the controller core and the pin
   input wire logic write_gate_in,
   input wire logic write_data_in,
   input wire logic read_data_low_in,
   // drive pins, active low
   output logic drive_sel_0_low_out,
   output logic drive_sel_1_low_out,
   output logic motor_out_0_low_out,
   output logic motor_out_1_low_out,
   // controller side controls
   output logic soft_reset_out,
   output logic dma_irq_pin_enable_out
);

   import fsr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   // host registers
   logic [7:0] doc_reg; // digital_output_control
   logic [7:0] doc_next;
   logic [1:0] tape_reg; // tape_drive_assign number
   logic [1:0] tape_next;

   // pin activity state
   logic read_data_low; // filtered read data pin
   logic rdata_prev_reg;
   logic wdata_prev_reg;
   logic write_gate_prev_reg;
   logic rdata_tog_reg;
   logic rdata_tog_next;
   logic wdata_tog_reg;
   logic wdata_tog_next;
   logic write_gate_lat_reg;
   logic write_gate_lat_next;
   logic rdata_lat_reg;
   logic rdata_lat_next;
   logic wdata_lat_reg;
   logic wdata_lat_next;

   // soft reset stretch
   logic [7:0] srst_cnt_reg;
   logic [7:0] srst_cnt_next;

   // drive pins
   logic ds0_low_reg;
   logic ds0_low_next;
   logic ds1_low_reg;
   logic ds1_low_next;
   logic mt0_low_reg;
   logic mt0_low_next;
   logic mt1_low_reg;
   logic mt1_low_next;
   logic srst_reg;
   logic srst_next;
   logic dma_en_reg;
   logic dma_en_next;

   // read answer
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] oe_reg;
   logic [7:0] oe_next;

   // edge events and strobes
   logic rdata_rise_evt; // low pin released: inactive edge
   logic wdata_fall_evt; // internal data inactive edge
   logic write_gate_rise_evt;
   logic dir_read;
   logic [7:0] status_b;

   ////////////////////////////////////////////////////////////////////////////
   // address match helper
   function automatic logic fsr_hit(input logic [9:0] addr, input logic [9:0] ref_addr);
      fsr_hit = (addr == ref_addr);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // read data pin comes from outside: synchronise and filter
   fsr_pin_sync u_rdata_sync
   (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(read_data_low_in),
      .level_out(read_data_low)
   );

   ////////////////////////////////////////////////////////////////////////////
   // edge detection on data and gate activity
   always_comb
   begin
      rdata_rise_evt = read_data_low & ~rdata_prev_reg; // R04
      wdata_fall_evt = wdata_prev_reg & ~write_data_in; // R04
      write_gate_rise_evt = write_gate_in & ~write_gate_prev_reg; // R07
      dir_read = io_rd_in & fsr_hit(io_addr_in, FSR_ADDR_DIGITAL_IN); // R22
   end

   ////////////////////////////////////////////////////////////////////////////
   // host register writes
   always_comb
   begin
      doc_next = doc_reg;
      tape_next = tape_reg;
      // output register takes a write at any time
      if (io_wr_in && fsr_hit(io_addr_in, FSR_ADDR_OUTPUT))
      begin
         doc_next = io_wdata_in; // R10 R17
      end
      // tape register keeps only the drive number
      if (io_wr_in && fsr_hit(io_addr_in, FSR_ADDR_TAPE))
      begin
         tape_next = io_wdata_in[1:0]; // R18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // toggles and latches of the drive activity
   always_comb
   begin
      rdata_tog_next = rdata_tog_reg ^ rdata_rise_evt; // R04
      wdata_tog_next = wdata_tog_reg ^ wdata_fall_evt; // R04
      write_gate_lat_next = write_gate_lat_reg;
      rdata_lat_next = rdata_lat_reg;
      wdata_lat_next = wdata_lat_reg;
      // digital input read clears the latches
      if (dir_read)
      begin
         write_gate_lat_next = 1'b0; // R22
         rdata_lat_next = 1'b0;
         wdata_lat_next = 1'b0;
      end
      // a new edge wins over the clear
      if (write_gate_rise_evt)
      begin
         write_gate_lat_next = 1'b1; // R07
      end
      if (rdata_rise_evt)
      begin
         rdata_lat_next = 1'b1; // R08
      end
      // write data latch is not qualified by write gate
      if (wdata_fall_evt)
      begin
         wdata_lat_next = 1'b1; // R08
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // soft reset: held while bit 2 is zero, stretched to the least width
   always_comb
   begin
      srst_cnt_next = srst_cnt_reg;
      if (!doc_reg[FSR_DOC_RESET_N])
      begin
         srst_cnt_next = 8'(SOFT_RST_CYC); // R12
      end
      else if (srst_cnt_reg != 8'h00)
      begin
         srst_cnt_next = srst_cnt_reg - 8'h01; // R13
      end
      // active from the first cycle bit 2 is low until the count ends
      srst_next = !doc_next[FSR_DOC_RESET_N] || (srst_cnt_next != 8'h00); // R12 R13
   end

   ////////////////////////////////////////////////////////////////////////////
   // drive select and motor decode, next pin levels
   always_comb
   begin
      logic sel_a; // drive 0 of the register view
      logic sel_b; // drive 1 of the register view
      sel_a = (doc_next[FSR_DOC_SEL_HI:FSR_DOC_SEL_LO] == 2'h0) && doc_next[FSR_DOC_MOTOR0]; // R11 R20
      sel_b = (doc_next[FSR_DOC_SEL_HI:FSR_DOC_SEL_LO] == 2'h1) && doc_next[FSR_DOC_MOTOR1]; // R11 R20
      if (swap_drives_in)
      begin
         // swapped: register drive 0 appears on pin drive 1
         ds0_low_next = ~sel_b; // R21
         ds1_low_next = ~sel_a; // R21
         mt0_low_next = ~doc_next[FSR_DOC_MOTOR1]; // R21
         mt1_low_next = ~doc_next[FSR_DOC_MOTOR0]; // R21
      end
      else
      begin
         // normal order
         ds0_low_next = ~sel_a; // R20
         ds1_low_next = ~sel_b; // R20
         mt0_low_next = ~doc_next[FSR_DOC_MOTOR0]; // R16 R20
         mt1_low_next = ~doc_next[FSR_DOC_MOTOR1]; // R16 R20
      end
      // dma and interrupt pins
      if (mode_in == FSR_MODE_EXTENDED)
      begin
         dma_en_next = 1'b1; // R15
      end
      else
      begin
         dma_en_next = doc_next[FSR_DOC_DMA_EN]; // R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status register b layout per mode
   always_comb
   begin
      status_b = 8'h00;
      case (mode_in) // R23
         FSR_MODE_EXTENDED:
         begin
            status_b[FSR_STB_MOTOR0] = ~mt0_low_reg; // R02
            status_b[FSR_STB_MOTOR1] = ~mt1_low_reg; // R02
            status_b[FSR_STB_WRITE_GATE] = write_gate_in; // R03
            status_b[FSR_STB_RDATA] = rdata_tog_reg; // R04
            status_b[FSR_STB_WDATA] = wdata_tog_reg; // R04
            status_b[FSR_STB_SEL0] = doc_reg[FSR_DOC_SEL_LO]; // R05
            status_b[FSR_STB_SEL1] = 1'b1; // R06
            status_b[FSR_STB_TOP] = 1'b1; // R06
         end
         FSR_MODE_LATCHED:
         begin
            // unsupported drive 2 and 3 selects read inactive
            status_b[FSR_STB_MOTOR0] = 1'b1; // R09
            status_b[FSR_STB_MOTOR1] = 1'b1; // R09
            status_b[FSR_STB_WRITE_GATE] = write_gate_lat_reg; // R07
            status_b[FSR_STB_RDATA] = rdata_lat_reg; // R08
            status_b[FSR_STB_WDATA] = wdata_lat_reg; // R08
            status_b[FSR_STB_SEL0] = ds0_low_reg; // R09
            status_b[FSR_STB_SEL1] = ds1_low_reg; // R09
            // second drive sense is absent: reads inactive
            status_b[FSR_STB_TOP] = 1'b1;
         end
         default:
         begin
            status_b = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // read answer, one cycle after the strobe
   always_comb
   begin
      rdata_next = 8'h00;
      oe_next = FSR_OE_NONE;
      if (io_rd_in)
      begin
         if (fsr_hit(io_addr_in, FSR_ADDR_STATUS_B))
         begin
            if (mode_in != FSR_MODE_PLAIN) // R01
            begin
               rdata_next = status_b;
               oe_next = FSR_OE_ALL;
            end
         end
         else if (fsr_hit(io_addr_in, FSR_ADDR_OUTPUT))
         begin
            rdata_next = doc_reg;
            oe_next = FSR_OE_ALL;
         end
         else if (fsr_hit(io_addr_in, FSR_ADDR_TAPE))
         begin
            // only the drive number is driven
            rdata_next = {6'h00, tape_reg};
            oe_next = FSR_OE_TAPE; // R19
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers: hardware reset loads their start values; soft reset touches none
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         doc_reg <= FSR_DOC_RESET; // R10
         tape_reg <= FSR_TAPE_RESET; // R19
         rdata_prev_reg <= 1'b1;
         wdata_prev_reg <= 1'b0;
         write_gate_prev_reg <= 1'b0;
         rdata_tog_reg <= 1'b0;
         wdata_tog_reg <= 1'b0;
         write_gate_lat_reg <= 1'b0;
         rdata_lat_reg <= 1'b0;
         wdata_lat_reg <= 1'b0;
         srst_cnt_reg <= 8'h00;
         srst_reg <= 1'b1;
         ds0_low_reg <= 1'b1;
         ds1_low_reg <= 1'b1;
         mt0_low_reg <= 1'b1;
         mt1_low_reg <= 1'b1;
         dma_en_reg <= (mode_in == FSR_MODE_EXTENDED); // R15
         rdata_reg <= 8'h00;
         oe_reg <= FSR_OE_NONE;
      end
      else
      begin
         doc_reg <= doc_next;
         tape_reg <= tape_next;
         rdata_prev_reg <= read_data_low;
         wdata_prev_reg <= write_data_in;
         write_gate_prev_reg <= write_gate_in;
         rdata_tog_reg <= rdata_tog_next;
         wdata_tog_reg <= wdata_tog_next;
         write_gate_lat_reg <= write_gate_lat_next;
         rdata_lat_reg <= rdata_lat_next;
         wdata_lat_reg <= wdata_lat_next;
         srst_cnt_reg <= srst_cnt_next;
         srst_reg <= srst_next;
         ds0_low_reg <= ds0_low_next;
         ds1_low_reg <= ds1_low_next;
         mt0_low_reg <= mt0_low_next;
         mt1_low_reg <= mt1_low_next;
         dma_en_reg <= dma_en_next;
         rdata_reg <= rdata_next;
         oe_reg <= oe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign io_rdata_out = rdata_reg;
   assign io_rdata_oe_out = oe_reg;
   assign drive_sel_0_low_out = ds0_low_reg;
   assign drive_sel_1_low_out = ds1_low_reg;
   assign motor_out_0_low_out = mt0_low_reg;
   assign motor_out_1_low_out = mt1_low_reg;
   assign soft_reset_out = srst_reg;
   assign dma_irq_pin_enable_out = dma_en_reg;

endmodule

// ==== rtl/fsr_pkg.sv ====
package fsr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // host i/o addresses at the primary base
   localparam logic [9:0] FSR_ADDR_STATUS_B = 10'h3F1;
   localparam logic [9:0] FSR_ADDR_OUTPUT = 10'h3F2;
   localparam logic [9:0] FSR_ADDR_TAPE = 10'h3F3;
   localparam logic [9:0] FSR_ADDR_DIGITAL_IN = 10'h3F7;

   ////////////////////////////////////////////////////////////////////////////
   // digital_output_control field positions
   localparam int FSR_DOC_SEL_LO = 0;
   localparam int FSR_DOC_SEL_HI = 1;
   localparam int FSR_DOC_RESET_N = 2;
   localparam int FSR_DOC_DMA_EN = 3;
   localparam int FSR_DOC_MOTOR0 = 4;
   localparam int FSR_DOC_MOTOR1 = 5;
   localparam int FSR_DOC_MOTOR2 = 6;
   localparam int FSR_DOC_MOTOR3 = 7;

   ////////////////////////////////////////////////////////////////////////////
   // drive_pin_status_b field positions
   localparam int FSR_STB_MOTOR0 = 0;
   localparam int FSR_STB_MOTOR1 = 1;
   localparam int FSR_STB_WRITE_GATE = 2;
   localparam int FSR_STB_RDATA = 3;
   localparam int FSR_STB_WDATA = 4;
   localparam int FSR_STB_SEL0 = 5;
   localparam int FSR_STB_SEL1 = 6;
   localparam int FSR_STB_TOP = 7;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and fixed read patterns
   localparam logic [7:0] FSR_DOC_RESET = 8'h00;
   localparam logic [1:0] FSR_TAPE_RESET = 2'h0;
   localparam logic [7:0] FSR_OE_ALL = 8'hFF;
   localparam logic [7:0] FSR_OE_NONE = 8'h00;
   localparam logic [7:0] FSR_OE_TAPE = 8'h03;

   ////////////////////////////////////////////////////////////////////////////
   // timing: least soft reset width
   localparam int FSR_CLK_PERIOD_PS = 8000;
   localparam int FSR_SOFT_RST_MIN_NS = 100;
   localparam int FSR_SOFT_RST_CYC = (FSR_SOFT_RST_MIN_NS * 1000 + FSR_CLK_PERIOD_PS - 1) / FSR_CLK_PERIOD_PS;

   ////////////////////////////////////////////////////////////////////////////
   // compatibility modes of the status register
   typedef enum logic [1:0]
   {
      FSR_MODE_PLAIN,
      FSR_MODE_EXTENDED,
      FSR_MODE_LATCHED
   } fsr_mode_t;

endpackage

// ==== rtl/fsr_pin_sync.sv ====
`timescale 1ns/1ps

// three-stage synchroniser with agreement filter for a pin input
module fsr_pin_sync
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // asynchronous pin level
   input wire logic pin_in,
   // filtered level in the clock domain
   output logic level_out
);

   logic stage1_reg; // metastability catcher, read only by stage2
   logic stage2_reg;
   logic stage3_reg;
   logic level_reg;
   logic level_next;

   ////////////////////////////////////////////////////////////////////////////
   // accept a change once stages two and three agree
   always_comb
   begin
      level_next = level_reg;
      if (stage2_reg == stage3_reg)
      begin
         level_next = stage3_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift chain and filtered level
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         stage1_reg <= 1'b1;
         stage2_reg <= 1'b1;
         stage3_reg <= 1'b1;
         level_reg <= 1'b1;
      end
      else
      begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;

endmodule

// ==== dv/fsr_regs_monitor.sv ====
`timescale 1ns/1ps
// concurrent checks on the register bank ports
module fsr_regs_monitor
#(
   parameter int SOFT_RST_CYC = 13
)
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // host port
   input wire logic [9:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic io_wr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic [7:0] io_rdata_oe_out,
   // configuration and activity
   input wire fsr_pkg::fsr_mode_t mode_in,
   input wire logic swap_drives_in,
   input wire logic write_gate_in,
   // drive pins and controls
   input wire logic drive_sel_0_low_out,
   input wire logic drive_sel_1_low_out,
   input wire logic motor_out_0_low_out,
   input wire logic motor_out_1_low_out,
   input wire logic soft_reset_out,
   input wire logic dma_irq_pin_enable_out
);
   import fsr_pkg::*;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////////////////////
   // run length of soft reset held high
   logic [7:0] hi_cnt_reg;
   logic [7:0] hi_cnt_next;
   // count up while high, saturate, clear when low
   always_comb
   begin
      hi_cnt_next = hi_cnt_reg + 8'h01;
      if (sys_rst_in || !soft_reset_out)
         hi_cnt_next = 8'h00;
      else if (hi_cnt_reg == 8'hFF)
         hi_cnt_next = hi_cnt_reg;
   end
   // register only
   always_ff @(posedge mclk_in)
      hi_cnt_reg <= hi_cnt_next;
   ////////////////////////////////////////////////////////////////////////////
   // host accesses
   sequence s_rd(a);
      io_rd_in && io_addr_in == a;
   endsequence
   sequence s_doc_wr;
      io_wr_in && io_addr_in == FSR_ADDR_OUTPUT;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_PLAIN_FLOAT: assert property (s_rd(FSR_ADDR_STATUS_B) ##0 mode_in == FSR_MODE_PLAIN |=>
      io_rdata_oe_out == FSR_OE_NONE) else $error("status b driven in plain mode");
   AST_EXT_FIXED: assert property (s_rd(FSR_ADDR_STATUS_B) ##0 mode_in == FSR_MODE_EXTENDED |=>
      io_rdata_oe_out == FSR_OE_ALL && io_rdata_out[7:6] == 2'b11) else $error("status b top bits wrong");
   AST_EXT_WRITE_GATE: assert property (s_rd(FSR_ADDR_STATUS_B) ##0 mode_in == FSR_MODE_EXTENDED |=>
      io_rdata_out[2] == $past(write_gate_in)) else $error("write gate status wrong");
   AST_ONE_SEL: assert property (drive_sel_0_low_out || drive_sel_1_low_out)
      else $error("two drives selected");
   AST_MOTOR_MAP: assert property (s_doc_wr |=> {motor_out_1_low_out, motor_out_0_low_out} ==
      ~(swap_drives_in ? {$past(io_wdata_in[4]), $past(io_wdata_in[5])} : $past(io_wdata_in[5:4])))
      else $error("motor pins wrong");
   AST_SEL_ZERO: assert property (s_doc_wr ##0 io_wdata_in[1:0] == 2'b00 && io_wdata_in[4] |=>
      (swap_drives_in ? !drive_sel_1_low_out : !drive_sel_0_low_out)) else $error("drive 0 select wrong");
   AST_SEL_HIGH: assert property (s_doc_wr ##0 io_wdata_in[1] |=>
      drive_sel_0_low_out && drive_sel_1_low_out) else $error("absent drive selected");
   AST_DMA_BIT: assert property (s_doc_wr ##0 mode_in != FSR_MODE_EXTENDED |=>
      dma_irq_pin_enable_out == $past(io_wdata_in[3])) else $error("dma enable wrong");
   AST_DMA_EXT: assert property (mode_in == FSR_MODE_EXTENDED |->
      dma_irq_pin_enable_out) else $error("dma pins disabled in extended mode");
   AST_SOFT_SET: assert property (s_doc_wr ##0 !io_wdata_in[2] |=> soft_reset_out [*2])
      else $error("soft reset not raised");
   AST_SOFT_WIDTH: assert property ($fell(soft_reset_out) |-> hi_cnt_reg >= SOFT_RST_CYC + 1)
      else $error("soft reset too short");
   AST_TAPE_OE: assert property (s_rd(FSR_ADDR_TAPE) |=> io_rdata_oe_out == FSR_OE_TAPE)
      else $error("tape read enables wrong");
endmodule
bind fsr_regs fsr_regs_monitor #(.SOFT_RST_CYC(SOFT_RST_CYC)) i_fsr_regs_monitor (.mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
   .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_rdata_oe_out(io_rdata_oe_out),
   .mode_in(mode_in), .swap_drives_in(swap_drives_in), .write_gate_in(write_gate_in),
   .drive_sel_0_low_out(drive_sel_0_low_out), .drive_sel_1_low_out(drive_sel_1_low_out),
   .motor_out_0_low_out(motor_out_0_low_out), .motor_out_1_low_out(motor_out_1_low_out),
   .soft_reset_out(soft_reset_out), .dma_irq_pin_enable_out(dma_irq_pin_enable_out));

// ==== dv/fsr_drive_model.sv ====
`timescale 1ns/1ps
// one drive on select 0: gives flux pulses only while selected and spinning
module fsr_drive_model
(
   // clock
   input wire logic mclk_in,
   // bench asks for one pulse
   input wire logic pulse_req_in,
   // drive pins from the controller
   input wire logic drive_sel_0_low_in,
   input wire logic motor_out_0_low_in,
   // read data pin, active low, pulled up when idle
   output logic read_data_low_out
);
   logic [1:0] low_cnt = 2'h0; // remaining low cycles
   // unselected or stopped drive ignores the request
   always @(posedge mclk_in)
   begin
      if (pulse_req_in && !drive_sel_0_low_in && !motor_out_0_low_in)
         low_cnt <= #1 2'h3;
      else if (low_cnt != 2'h0)
         low_cnt <= #1 low_cnt - 2'h1;
   end
   assign read_data_low_out = (low_cnt == 2'h0);
endmodule

// ==== dv/floppy_status_output_tape_regs_tb_top.sv ====
`timescale 1ns/1ps
// bench for the status, output and tape register bank
module floppy_status_output_tape_regs_tb_top;
   import fsr_pkg::*;
   localparam int SRC = 4; // shortened soft reset stretch
   ////////////////////////////////////////////////////////////////////////////
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [9:0] io_addr_in = 10'h000;
   logic io_rd_in = 1'b0;
   logic io_wr_in = 1'b0;
   logic [7:0] io_wdata_in = 8'h00;
   logic [7:0] io_rdata_out, io_rdata_oe_out;
   fsr_mode_t mode_in = FSR_MODE_PLAIN;
   logic swap_drives_in = 1'b0;
   logic write_gate_in = 1'b0;
   logic write_data_in = 1'b0;
   logic read_data_low_in;
   logic pulse_req = 1'b0;
   logic drive_sel_0_low_out, drive_sel_1_low_out, motor_out_0_low_out, motor_out_1_low_out;
   logic soft_reset_out, dma_irq_pin_enable_out;
   logic [7:0] d;
   logic [5:0] e;
   logic x0, x1, b4, b5;
   int err_count = 0;
   int checks = 0;
   always #4 mclk_in = ~mclk_in;
   ////////////////////////////////////////////////////////////////////////////
   fsr_regs #(.SOFT_RST_CYC(SRC)) i_fsr_regs (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in),
      .io_rdata_out(io_rdata_out), .io_rdata_oe_out(io_rdata_oe_out), .mode_in(mode_in),
      .swap_drives_in(swap_drives_in), .write_gate_in(write_gate_in), .write_data_in(write_data_in),
      .read_data_low_in(read_data_low_in), .drive_sel_0_low_out(drive_sel_0_low_out),
      .drive_sel_1_low_out(drive_sel_1_low_out), .motor_out_0_low_out(motor_out_0_low_out),
      .motor_out_1_low_out(motor_out_1_low_out), .soft_reset_out(soft_reset_out),
      .dma_irq_pin_enable_out(dma_irq_pin_enable_out));
   fsr_drive_model i_fsr_drive_model (.mclk_in(mclk_in), .pulse_req_in(pulse_req),
      .drive_sel_0_low_in(drive_sel_0_low_out), .motor_out_0_low_in(motor_out_0_low_out),
      .read_data_low_out(read_data_low_in));
   ////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // pins as {sel1, sel0, motor1, motor0, soft reset, dma enable}
   function automatic logic [15:0] pins();
      return {10'h000, drive_sel_1_low_out, drive_sel_0_low_out, motor_out_1_low_out,
         motor_out_0_low_out, soft_reset_out, dma_irq_pin_enable_out};
   endfunction
   // hardware reset with new static configuration
   task automatic hw_reset(input fsr_mode_t m, input logic sw);
      mode_in = m;
      swap_drives_in = sw;
      sys_rst_in = 1'b1;
      repeat (12) @(posedge mclk_in);
      #1 sys_rst_in = 1'b0;
   endtask
   // one write strobe, then an idle edge
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      io_addr_in = a;
      io_wdata_in = v;
      io_wr_in = 1'b1;
      @(posedge mclk_in);
      #1 io_wr_in = 1'b0;
      @(posedge mclk_in);
      #1;
   endtask
   // one read strobe; {enables, data} checked in the answer cycle
   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      io_addr_in = a;
      io_rd_in = 1'b1;
      @(posedge mclk_in);
      #1 io_rd_in = 1'b0;
      chk("read", exp, {io_rdata_oe_out, io_rdata_out});
      @(posedge mclk_in);
      #1;
   endtask
   // falling edge of write data, optionally behind a write gate pulse
   task automatic pulses(input logic gate, input logic flux);
      write_gate_in = gate;
      write_data_in = 1'b1;
      @(posedge mclk_in);
      #1 write_gate_in = 1'b0;
      write_data_in = 1'b0;
      pulse_req = flux;
      @(posedge mclk_in);
      #1 pulse_req = 1'b0;
      repeat (10) @(posedge mclk_in);
      #1;
   endtask
   // verdict and end of run
   task automatic results;
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial
   begin
      repeat (5000) @(posedge mclk_in);
      err_count++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      // plain mode, normal then swapped decode
      for (int sw = 0; sw < 2; sw++)
      begin
         hw_reset(FSR_MODE_PLAIN, sw[0]);
         chk("pins", 16'h003E, pins());
         rd(FSR_ADDR_OUTPUT, 16'hFF00);
         rd(FSR_ADDR_STATUS_B, 16'h0000);
         rd(FSR_ADDR_TAPE, 16'h0300);
         for (int k = 0; k < 8; k++)
         begin
            b5 = k[2];
            b4 = ~k[2];
            d = {2'b11, b5, b4, 4'h8} | {6'h00, k[1:0]};
            x0 = (k[1:0] == 2'b00) && b4;
            x1 = (k[1:0] == 2'b01) && b5;
            e = sw[0] ? {~x0, ~x1, ~b4, ~b5, 2'b11} : {~x1, ~x0, ~b5, ~b4, 2'b11};
            wr(FSR_ADDR_OUTPUT, d);
            chk("pins", {10'h000, e}, pins());
         end
         rd(FSR_ADDR_OUTPUT, {8'hFF, d});
         wr(FSR_ADDR_OUTPUT, 8'h1C);
         chk("pins", sw[0] ? 16'h0017 : 16'h002B, pins());
         repeat (SRC - 2) @(posedge mclk_in);
         #1 chk("stretch", 16'h0001, {15'h0000, soft_reset_out});
         @(posedge mclk_in);
         #1 chk("release", 16'h0000, {15'h0000, soft_reset_out});
         wr(FSR_ADDR_TAPE, 8'hFF);
         wr(FSR_ADDR_OUTPUT, 8'h18);
         chk("soft", 16'h0001, {15'h0000, soft_reset_out});
         rd(FSR_ADDR_OUTPUT, 16'hFF18);
         wr(FSR_ADDR_OUTPUT, 8'h2D);
         chk("pins", sw[0] ? 16'h002B : 16'h0017, pins());
         rd(FSR_ADDR_TAPE, 16'h0303);
      end
      // extended status mode
      hw_reset(FSR_MODE_EXTENDED, 1'b0);
      chk("pins", 16'h003F, pins());
      rd(FSR_ADDR_STATUS_B, 16'hFFC0);
      wr(FSR_ADDR_OUTPUT, 8'h11);
      chk("pins", 16'h003B, pins());
      rd(FSR_ADDR_STATUS_B, 16'hFFE1);
      write_gate_in = 1'b1;
      rd(FSR_ADDR_STATUS_B, 16'hFFE5);
      pulses(1'b0, 1'b0);
      rd(FSR_ADDR_STATUS_B, 16'hFFF1);
      pulses(1'b0, 1'b0);
      rd(FSR_ADDR_STATUS_B, 16'hFFE1);
      wr(FSR_ADDR_OUTPUT, 8'h14);
      pulses(1'b0, 1'b1);
      rd(FSR_ADDR_STATUS_B, 16'hFFD9);
      // latched status mode
      hw_reset(FSR_MODE_LATCHED, 1'b0);
      rd(FSR_ADDR_STATUS_B, 16'hFFE3);
      wr(FSR_ADDR_OUTPUT, 8'h14);
      chk("pins", 16'h002A, pins());
      pulses(1'b1, 1'b1);
      rd(FSR_ADDR_STATUS_B, 16'hFFDF);
      rd(FSR_ADDR_STATUS_B, 16'hFFDF);
      rd(FSR_ADDR_DIGITAL_IN, 16'h0000);
      rd(FSR_ADDR_STATUS_B, 16'hFFC3);
      results();
   end
endmodule
